// [gafm_pkg.sv]
// Purpose: shared constants and carriers for the pin function mux
// Assumes: 32-bit classic wishbone, word aligned registers
// Notes:   register index times four is the byte address
package gafm_pkg;

  // ----------------------------------------
  // register map (word indices)
  // ----------------------------------------
  localparam logic [11:0] IDX_PORT_BASE = 12'hFD0;
  localparam logic [1:0]  REG_SEL       = 2'h0;
  localparam logic [1:0]  REG_WIN       = 2'h1;
  localparam logic [1:0]  REG_IN        = 2'h2;
  localparam logic [1:0]  REG_OUT       = 2'h3;
  localparam logic [11:0] IDX_XTAL      = 12'hFE0;
  localparam logic [11:0] IDX_LED       = 12'hFE1;
  localparam logic [11:0] IDX_EDGE      = 12'hFE2;

  // ----------------------------------------
  // subregister selector codes
  // ----------------------------------------
  localparam logic [7:0] SUB_DIR  = 8'h01;
  localparam logic [7:0] SUB_AF   = 8'h02;
  localparam logic [7:0] SUB_OD   = 8'h03;
  localparam logic [7:0] SUB_HD   = 8'h04;
  localparam logic [7:0] SUB_WAKE = 8'h05;
  localparam logic [7:0] SUB_PU   = 8'h06;
  localparam logic [7:0] SUB_FS1  = 8'h07;
  localparam logic [7:0] SUB_FS2  = 8'h08;

  // ----------------------------------------
  // reset values
  // ----------------------------------------
  localparam logic [7:0]  RST_SEL   = 8'h00;
  localparam logic [7:0]  RST_DIR   = 8'hFF;
  localparam logic [7:0]  RST_ZERO  = 8'h00;
  localparam logic [7:0]  RST_FS1_D = 8'h01;
  localparam logic [15:0] RST_LED   = 16'h0000;
  localparam logic [7:0]  RST_EDGE  = 8'hFF;

  // ----------------------------------------
  // ports and field positions
  // ----------------------------------------
  localparam int PORT_A   = 0;
  localparam int PORT_B   = 1;
  localparam int PORT_C   = 2;
  localparam int PORT_D   = 3;
  localparam int XTAL_BIT = 0;
  localparam int PA_T0IO  = 0;
  localparam int PA_T0OUT = 1;
  localparam int PA_T1IO  = 6;
  localparam int PA_TIMER_ONE_OUTPUT = 7;
  localparam int PB_EXT_CLOCK_INPUT = 3;
  localparam int PB_NANA  = 6;
  localparam int PC_COMPARATOR_RESULT_OUT  = 3;
  localparam int PC_NANA  = 3;
  localparam int PD_RST   = 0;

  // led sink level codes, two bits per port c pin
  localparam logic [1:0] LED_3MA  = 2'h0;
  localparam logic [1:0] LED_7MA  = 2'h1;
  localparam logic [1:0] LED_13MA = 2'h2;
  localparam logic [1:0] LED_20MA = 2'h3;

  typedef struct packed {
    logic [7:0] dir;
    logic [7:0] af;
    logic [7:0] od;
    logic [7:0] hd;
    logic [7:0] wake;
    logic [7:0] pu;
    logic [7:0] fs1;
    logic [7:0] fs2;
  } gafm_cfg_t;

  typedef struct packed {
    logic [7:0] dout;
    logic [7:0] oe;
    logic [7:0] od;
    logic [7:0] hd;
    logic [7:0] pu;
  } gafm_pad_t;

endpackage : gafm_pkg

// [gafm_port.sv]
// Purpose: one port's selector, subregisters and output value
// Assumes: write strobes are single cycle and already decoded
// Notes:   port without function sets reads them as zero
`timescale 1ns/1ps
module gafm_port
  import gafm_pkg::*;
#(
  parameter logic       HAS_FS  = 1'b1,
  parameter logic [7:0] FS1_RST = 8'h00
) (
  input  wire logic       clk_i,
  input  wire logic       rst_i,
  input  wire logic       ce_i,
  input  wire logic       wr_sel_i,
  input  wire logic       wr_win_i,
  input  wire logic       wr_out_i,
  input  wire logic [7:0] wdata_i,
  output logic      [7:0] sel_o,
  output logic      [7:0] win_o,
  output logic      [7:0] out_o,
  output gafm_cfg_t       cfg_o
);

  logic [7:0] sel_r;
  logic [7:0] out_r;
  gafm_cfg_t  cfg_r;

  // ----------------------------------------
  // selector and output value
  // ----------------------------------------
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      sel_r <= RST_SEL;
      out_r <= RST_ZERO;
    end else if (ce_i) begin
      if (wr_sel_i) begin
        sel_r <= wdata_i;
      end
      if (wr_out_i) begin
        out_r <= wdata_i;
      end
    end
  end

  // ----------------------------------------
  // subregisters behind the window
  // ----------------------------------------
  // selector code decode
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      cfg_r.dir  <= RST_DIR;
      cfg_r.af   <= RST_ZERO;
      cfg_r.od   <= RST_ZERO;
      cfg_r.hd   <= RST_ZERO;
      cfg_r.wake <= RST_ZERO;
      cfg_r.pu   <= RST_ZERO;
      cfg_r.fs1  <= FS1_RST;
      cfg_r.fs2  <= RST_ZERO;
    end else if (ce_i && wr_win_i) begin
      case (sel_r)
        SUB_DIR:  cfg_r.dir  <= wdata_i;
        SUB_AF:   cfg_r.af   <= wdata_i;
        SUB_OD:   cfg_r.od   <= wdata_i;
        SUB_HD:   cfg_r.hd   <= wdata_i;
        SUB_WAKE: cfg_r.wake <= wdata_i;
        SUB_PU:   cfg_r.pu   <= wdata_i;
        SUB_FS1:  cfg_r.fs1  <= HAS_FS ? wdata_i : RST_ZERO;
        SUB_FS2:  cfg_r.fs2  <= HAS_FS ? wdata_i : RST_ZERO;
        // code 00 and 09 up guard against stray writes
        default: ;
      endcase
    end
  end

  always_comb begin
    case (sel_r)
      SUB_DIR:  win_o = cfg_r.dir;
      SUB_AF:   win_o = cfg_r.af;
      SUB_OD:   win_o = cfg_r.od;
      SUB_HD:   win_o = cfg_r.hd;
      SUB_WAKE: win_o = cfg_r.wake;
      SUB_PU:   win_o = cfg_r.pu;
      SUB_FS1:  win_o = cfg_r.fs1;
      SUB_FS2:  win_o = cfg_r.fs2;
      default:  win_o = RST_ZERO;
    endcase
  end

  assign sel_o = sel_r;
  assign out_o = out_r;
  assign cfg_o = cfg_r;

endmodule : gafm_port

// [gafm_top.sv]
// Purpose: pin function mux for general purpose ports a to d
// Assumes: pad inputs are synchronous to clk_i
// Notes:   pad outputs are registered, one cycle behind config
`timescale 1ns/1ps
module gafm_top
  import gafm_pkg::*;
(
  input  wire logic            clk_i,
  input  wire logic            rst_i,
  input  wire logic            ce_i,
  input  wire logic            wb_cyc_i,
  input  wire logic            wb_stb_i,
  input  wire logic            wb_we_i,
  input  wire logic [13:0]     wb_adr_i,
  input  wire logic [3:0]      wb_sel_i,
  input  wire logic [31:0]     wb_dat_i,
  output logic      [31:0]     wb_dat_o,
  output logic                 wb_ack_o,
  input  wire logic [3:0][7:0] pad_in_i,
  output gafm_pad_t [3:0]      pad_o,
  input  wire logic            tmr0_out_i,
  input  wire logic            tmr0_out_n_i,
  input  wire logic            tmr0_drive_i,
  input  wire logic            tmr1_out_i,
  input  wire logic            tmr1_out_n_i,
  input  wire logic            tmr1_drive_i,
  output logic                 tmr0_in_o,
  output logic                 tmr1_in_o,
  output logic                 xtal_owns_o,
  output logic      [5:0]      pb_analog_o,
  output logic                 ext_clock_input_o,
  output logic                 ext_clock_sel_o,
  output logic      [2:0]      pc_analog_o,
  input  wire logic            comparator_result_out_i,
  output logic      [7:0]      led_active_o,
  output logic      [15:0]     led_level_o,
  input  wire logic            reset_drive_i,
  output logic                 reset_pin_o,
  output logic      [7:0]      irq_a_o,
  output logic      [7:0]      irq_c_o
);

  // ----------------------------------------
  // bus decode
  // ----------------------------------------
  logic [11:0]     idx;
  logic            req;
  logic            hit_port;
  logic [1:0]      pnum;
  logic [1:0]      rnum;
  logic            wr_go;
  logic            ack_r;
  logic [31:0]     dat_r;
  logic [31:0]     rd_nxt;
  logic [3:0]      wr_sel;
  logic [3:0]      wr_win;
  logic [3:0]      wr_out;
  logic [3:0][7:0] sel_v;
  logic [3:0][7:0] win_v;
  logic [3:0][7:0] out_v;
  gafm_cfg_t [3:0] cfg;
  logic            xtal_r;
  logic [15:0]     led_r;
  logic [7:0]      edge_r;
  logic [3:0][7:0] prev_r;
  gafm_pad_t [3:0] pad_nxt;
  gafm_pad_t [3:0] pad_r;

  assign idx      = wb_adr_i[13:2];
  assign req      = wb_cyc_i && wb_stb_i;
  assign hit_port = (idx[11:4] == IDX_PORT_BASE[11:4]);
  assign pnum     = idx[3:2];
  assign rnum     = idx[1:0];
  // write lands on the edge where the master sees ack
  assign wr_go    = req && wb_we_i && ack_r && wb_sel_i[0];

  // one wait state: ack follows the take edge, so a held request is not taken twice
  // ack drops after one cycle even if the master keeps cyc up
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack_r <= 1'b0;
    end else if (ce_i) begin
      ack_r <= req && !ack_r;
    end
  end

  always_comb begin
    for (int p = 0; p < 4; p++) begin
      wr_sel[p] = wr_go && hit_port && (pnum == 2'(p)) && (rnum == REG_SEL);
      wr_win[p] = wr_go && hit_port && (pnum == 2'(p)) && (rnum == REG_WIN);
      wr_out[p] = wr_go && hit_port && (pnum == 2'(p)) && (rnum == REG_OUT);
    end
  end

  // unmapped reads give zero, unmapped writes are dropped
  always_comb begin
    rd_nxt = 32'h0000_0000;
    if (hit_port) begin
      case (rnum)
        REG_SEL: rd_nxt[7:0] = sel_v[pnum];
        REG_WIN: rd_nxt[7:0] = win_v[pnum];
        REG_IN:  rd_nxt[7:0] = pad_in_i[pnum];
        REG_OUT: rd_nxt[7:0] = out_v[pnum];
        default: rd_nxt = 32'h0000_0000;
      endcase
    end else if (idx == IDX_XTAL) begin
      rd_nxt[XTAL_BIT] = xtal_r;
    end else if (idx == IDX_LED) begin
      rd_nxt[15:0] = led_r;
    end else if (idx == IDX_EDGE) begin
      rd_nxt[7:0] = edge_r;
    end
  end

  // read data is captured at the take edge and stands until the next take
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      dat_r <= 32'h0000_0000;
    end else if (ce_i && req && !ack_r) begin
      dat_r <= rd_nxt;
    end
  end

  assign wb_ack_o = ack_r;
  assign wb_dat_o = dat_r;

  // ----------------------------------------
  // port register banks
  // ----------------------------------------
  // port a keeps its function sets at zero, so software reads them back as 0
  // subregister set per port
  genvar gp;
  generate
    for (gp = 0; gp < 4; gp++) begin : g_port
      gafm_port #(
        .HAS_FS  (gp != PORT_A),
        .FS1_RST ((gp == PORT_D) ? RST_FS1_D : RST_ZERO)
      ) u_port (
        .clk_i    (clk_i),
        .rst_i    (rst_i),
        .ce_i     (ce_i),
        .wr_sel_i (wr_sel[gp]),
        .wr_win_i (wr_win[gp]),
        .wr_out_i (wr_out[gp]),
        .wdata_i  (wb_dat_i[7:0]),
        .sel_o    (sel_v[gp]),
        .win_o    (win_v[gp]),
        .out_o    (out_v[gp]),
        .cfg_o    (cfg[gp])
      );
    end
  endgenerate

  // ----------------------------------------
  // block level control registers
  // ----------------------------------------
  // crystal, led levels and port a edge select live outside the port banks
  // a led write with lane 1 off only touches the low half
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      xtal_r <= 1'b0;
      led_r  <= RST_LED;
      edge_r <= RST_EDGE;
    end else if (ce_i && wr_go) begin
      if (idx == IDX_XTAL) begin
        xtal_r <= wb_dat_i[XTAL_BIT];
      end
      if (idx == IDX_LED && wb_sel_i[1]) begin
        led_r <= wb_dat_i[15:0];
      end else if (idx == IDX_LED) begin
        led_r[7:0] <= wb_dat_i[7:0];
      end
      if (idx == IDX_EDGE) begin
        edge_r <= wb_dat_i[7:0];
      end
    end
  end

  // ----------------------------------------
  // pin function mux
  // ----------------------------------------
  // built from config first, then each function overrides its own pins
  // later overrides win, so the crystal beats the timers on port a
  // hazard: a pin with af set and no function listed here is left released
  always_comb begin
    for (int p = 0; p < 4; p++) begin
      pad_nxt[p].dout = out_v[p];
      pad_nxt[p].oe   = ~cfg[p].dir;
      pad_nxt[p].od   = cfg[p].od;
      pad_nxt[p].hd   = cfg[p].hd;
      pad_nxt[p].pu   = cfg[p].pu;
      for (int b = 0; b < 8; b++) begin
        if (cfg[p].af[b]) begin
          pad_nxt[p].oe[b] = 1'b0;
        end
      end
    end
    if (cfg[PORT_A].af[PA_T0IO]) begin
      pad_nxt[PORT_A].dout[PA_T0IO] = tmr0_out_n_i;
      pad_nxt[PORT_A].oe[PA_T0IO]   = tmr0_drive_i;
    end
    if (cfg[PORT_A].af[PA_T0OUT]) begin
      pad_nxt[PORT_A].dout[PA_T0OUT] = tmr0_out_i;
      pad_nxt[PORT_A].oe[PA_T0OUT]   = 1'b1;
    end
    if (cfg[PORT_A].af[PA_T1IO]) begin
      pad_nxt[PORT_A].dout[PA_T1IO] = tmr1_out_n_i;
      pad_nxt[PORT_A].oe[PA_T1IO]   = tmr1_drive_i;
    end
    if (cfg[PORT_A].af[PA_TIMER_ONE_OUTPUT]) begin
      pad_nxt[PORT_A].dout[PA_TIMER_ONE_OUTPUT] = tmr1_out_i;
      pad_nxt[PORT_A].oe[PA_TIMER_ONE_OUTPUT]   = 1'b1;
    end
    if (xtal_r) begin
      pad_nxt[PORT_A].dout[1:0] = 2'h0;
      pad_nxt[PORT_A].oe[1:0]   = 2'h0;
      pad_nxt[PORT_A].od[1:0]   = 2'h0;
      pad_nxt[PORT_A].hd[1:0]   = 2'h0;
      pad_nxt[PORT_A].pu[1:0]   = 2'h0;
    end
    // sink only: the pin is pulled low or released, never driven high
    // led sink only with set-one
    for (int b = 0; b < 8; b++) begin
      if (cfg[PORT_C].af[b] && cfg[PORT_C].fs1[b]) begin
        pad_nxt[PORT_C].dout[b] = 1'b0;
        pad_nxt[PORT_C].oe[b]   = out_v[PORT_C][b];
      end
    end
    if (cfg[PORT_C].af[PC_COMPARATOR_RESULT_OUT] && !cfg[PORT_C].fs1[PC_COMPARATOR_RESULT_OUT]) begin
      pad_nxt[PORT_C].dout[PC_COMPARATOR_RESULT_OUT] = comparator_result_out_i;
      pad_nxt[PORT_C].oe[PC_COMPARATOR_RESULT_OUT]   = 1'b1;
    end
    if (cfg[PORT_D].fs1[PD_RST]) begin
      pad_nxt[PORT_D].dout[PD_RST] = 1'b0;
      pad_nxt[PORT_D].oe[PD_RST]   = reset_drive_i;
      pad_nxt[PORT_D].od[PD_RST]   = 1'b1;
    end else begin
      pad_nxt[PORT_D].oe[PD_RST] = 1'b1;
    end
    // port d has a single pin
    pad_nxt[PORT_D].dout[7:1] = 7'h00;
    pad_nxt[PORT_D].oe[7:1]   = 7'h00;
  end

  // ----------------------------------------
  // pad registers
  // ----------------------------------------
  // registering the pads costs a cycle but keeps decode glitches off the pins
  // reset pin live from power-up
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      pad_r                     <= '0;
      pad_r[PORT_D].od[PD_RST]  <= 1'b1;
    end else if (ce_i) begin
      pad_r <= pad_nxt;
    end
  end

  assign pad_o = pad_r;

  // ----------------------------------------
  // peripheral side signals
  // ----------------------------------------
  // peripheral inputs read as 0 whenever their pin is not handed over, except reset_pin_o, which reads 1
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      tmr0_in_o         <= 1'b0;
      tmr1_in_o         <= 1'b0;
      xtal_owns_o       <= 1'b0;
      pb_analog_o       <= 6'h00;
      ext_clock_input_o <= 1'b0;
      ext_clock_sel_o   <= 1'b0;
      pc_analog_o       <= 3'h0;
      led_active_o      <= 8'h00;
      reset_pin_o       <= 1'b1;
    end else if (ce_i) begin
      tmr0_in_o   <= cfg[PORT_A].af[PA_T0IO] && !xtal_r && pad_in_i[PORT_A][PA_T0IO];
      tmr1_in_o   <= cfg[PORT_A].af[PA_T1IO] && pad_in_i[PORT_A][PA_T1IO];
      xtal_owns_o <= xtal_r;
      pb_analog_o <= cfg[PORT_B].af[PB_NANA-1:0] & cfg[PORT_B].fs1[PB_NANA-1:0];
      ext_clock_sel_o   <= cfg[PORT_B].af[PB_EXT_CLOCK_INPUT] && !cfg[PORT_B].fs1[PB_EXT_CLOCK_INPUT];
      ext_clock_input_o <= cfg[PORT_B].af[PB_EXT_CLOCK_INPUT] && !cfg[PORT_B].fs1[PB_EXT_CLOCK_INPUT]
                           && pad_in_i[PORT_B][PB_EXT_CLOCK_INPUT];
      pc_analog_o  <= cfg[PORT_C].af[PC_NANA-1:0] & cfg[PORT_C].fs1[PC_NANA-1:0];
      led_active_o <= cfg[PORT_C].af & cfg[PORT_C].fs1;
      reset_pin_o  <= cfg[PORT_D].fs1[PD_RST] ? pad_in_i[PORT_D][PD_RST] : 1'b1;
    end
  end

  // ----------------------------------------
  // led sink levels
  // ----------------------------------------
  // levels pass straight through; the pad cell decodes them
  // two-bit sink level per pin
  assign led_level_o = led_r;

  // ----------------------------------------
  // pin interrupt edges
  // ----------------------------------------
  // history loads the live pins during reset, so release brings no false edge
  // port a edge select: 1 rising, 0 falling; port c pulses on both
  // selected edge or any edge
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      prev_r  <= pad_in_i;
      irq_a_o <= 8'h00;
      irq_c_o <= 8'h00;
    end else if (ce_i) begin
      prev_r  <= pad_in_i;
      irq_a_o <= (edge_r & pad_in_i[PORT_A] & ~prev_r[PORT_A])
               | (~edge_r & ~pad_in_i[PORT_A] & prev_r[PORT_A]);
      irq_c_o <= pad_in_i[PORT_C] ^ prev_r[PORT_C];
    end
  end

endmodule : gafm_top

// [gafm_pins.sv]
// Purpose: board side of the four ports
// Assumes: a released pin shows the level the bench sets on the board
// Notes:   an open drain high is left to the board level
`timescale 1ns/1ps
module gafm_pins
  import gafm_pkg::*;
(
  input  wire gafm_pad_t [3:0]      pad_i,
  input  wire logic      [3:0][7:0] board_i,
  output logic           [3:0][7:0] lvl_o
);
  // a driven pin wins over the board, except an open drain high
  always_comb begin
    for (int p = 0; p < 4; p++) begin
      for (int b = 0; b < 8; b++) begin
        if (pad_i[p].oe[b] && !(pad_i[p].od[b] && pad_i[p].dout[b])) begin
          lvl_o[p][b] = pad_i[p].dout[b];
        end else begin
          lvl_o[p][b] = board_i[p][b];
        end
      end
    end
  end
endmodule : gafm_pins

// [gafm_top_chk.sv]
// Purpose: port level checks for the pin function mux
// Assumes: one clock, synchronous reset
// Notes:   pad outputs trail config by one cycle
`timescale 1ns/1ps
module gafm_top_chk
  import gafm_pkg::*;
(
  input wire logic                 clk_i,
  input wire logic                 rst_i,
  input wire logic                 ce_i,
  input wire logic                 wb_cyc_i,
  input wire logic                 wb_stb_i,
  input wire logic                 wb_ack_o,
  input wire logic      [3:0][7:0] pad_in_i,
  input wire gafm_pad_t [3:0]      pad_o,
  input wire logic                 xtal_owns_o,
  input wire logic      [5:0]      pb_analog_o,
  input wire logic                 ext_clock_input_o,
  input wire logic                 ext_clock_sel_o,
  input wire logic      [7:0]      led_active_o,
  input wire logic      [7:0]      irq_a_o,
  input wire logic      [7:0]      irq_c_o
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);
  // ----------------------------------------
  // bus and pins
  // ----------------------------------------
  sequence s_take;
    wb_cyc_i && wb_stb_i && !wb_ack_o && ce_i;
  endsequence
  sequence s_pulse;
    wb_ack_o ##1 !wb_ack_o;
  endsequence
  // edge history is valid from the first cycle after reset; the check waits two clean cycles for its $past values
  sequence s_clean;
    $past(ce_i) && $past(ce_i, 2) && !$past(rst_i) && !$past(rst_i, 2);
  endsequence
  property p_ack_once;
    s_take |=> s_pulse;
  endproperty
  property p_pd0_rst;
    $past(rst_i) |-> pad_o[PORT_D].od[0];
  endproperty
  property p_xtal;
    xtal_owns_o && $past(xtal_owns_o) |-> pad_o[PORT_A].oe[1:0] == 2'h0 && pad_o[PORT_A].pu[1:0] == 2'h0;
  endproperty
  property p_led;
    led_active_o != 8'h00 |-> (led_active_o & pad_o[PORT_C].oe & pad_o[PORT_C].dout) == 8'h00;
  endproperty
  property p_pb_rel;
    pb_analog_o != 6'h00 |-> (pb_analog_o & pad_o[PORT_B].oe[5:0]) == 6'h00;
  endproperty
  property p_clk;
    ext_clock_sel_o && $past(ce_i) && !$past(rst_i) |-> ext_clock_input_o == $past(pad_in_i[PORT_B][PB_EXT_CLOCK_INPUT]);
  endproperty
  property p_irq_c;
    s_clean |-> irq_c_o == ($past(pad_in_i[PORT_C]) ^ $past(pad_in_i[PORT_C], 2));
  endproperty
  property p_irq_a;
    s_clean |-> (irq_a_o & ~($past(pad_in_i[PORT_A]) ^ $past(pad_in_i[PORT_A], 2))) == 8'h00;
  endproperty
  a_ack_once: assert property (p_ack_once) else $error("ack not a single pulse");
  a_pd0_rst: assert property (p_pd0_rst) else $error("pd0 not reset pin");
  a_xtal: assert property (p_xtal) else $error("crystal pins still driven");
  a_led: assert property (p_led) else $error("led pin driven high");
  a_pb_rel: assert property (p_pb_rel) else $error("analog pin driven");
  a_clk: assert property (p_clk) else $error("clock input wrong");
  a_irq_c: assert property (p_irq_c) else $error("port c edge pulse wrong");
  a_irq_a: assert property (p_irq_a) else $error("port a pulse without edge");
endmodule : gafm_top_chk

bind gafm_top gafm_top_chk i_chk (.clk_i(clk_i), .rst_i(rst_i), .ce_i(ce_i), .wb_cyc_i(wb_cyc_i),
  .wb_stb_i(wb_stb_i), .wb_ack_o(wb_ack_o), .pad_in_i(pad_in_i), .pad_o(pad_o), .xtal_owns_o(xtal_owns_o),
  .pb_analog_o(pb_analog_o), .ext_clock_input_o(ext_clock_input_o), .ext_clock_sel_o(ext_clock_sel_o),
  .led_active_o(led_active_o), .irq_a_o(irq_a_o), .irq_c_o(irq_c_o));

// [tb_gafm_top.sv]
// Purpose: register and pin tests of the pin function mux
// Assumes: classic wishbone, one clock at 200 MHz
// Notes:   clock enable is held high throughout
`timescale 1ns/1ps
module tb_gafm_top
  import gafm_pkg::*;
;
  logic            clk_i = 1'h0, rst_i = 1'h1, cyc = 1'h0, stb = 1'h0, we = 1'h0;
  logic [13:0]     adr = 14'h0000;
  logic [31:0]     wdat = 32'h0, rdat;
  logic [3:0][7:0] pad_in, board = '1;
  gafm_pad_t [3:0] pad;
  logic            t0 = 1'h0, t0n = 1'h0, t0d = 1'h0, t1 = 1'h0, t1n = 1'h0, t1d = 1'h0, cmp = 1'h0, rdrv = 1'h0;
  logic            ack, ti0, ti1, xo, eci, ecs, rpin;
  logic [5:0]      pban;
  logic [2:0]      pcan;
  logic [7:0]      leda, irqa, irqc;
  logic [15:0]     ledl, s;
  logic [7:0]      ex;
  int              errors = 0, n_compared = 0, cycles = 0;

  gafm_top i_dut (.clk_i(clk_i), .rst_i(rst_i), .ce_i(1'h1), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
    .wb_adr_i(adr), .wb_sel_i(4'hF), .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack), .pad_in_i(pad_in),
    .pad_o(pad), .tmr0_out_i(t0), .tmr0_out_n_i(t0n), .tmr0_drive_i(t0d), .tmr1_out_i(t1), .tmr1_out_n_i(t1n),
    .tmr1_drive_i(t1d), .tmr0_in_o(ti0), .tmr1_in_o(ti1), .xtal_owns_o(xo), .pb_analog_o(pban),
    .ext_clock_input_o(eci), .ext_clock_sel_o(ecs), .pc_analog_o(pcan), .comparator_result_out_i(cmp),
    .led_active_o(leda), .led_level_o(ledl), .reset_drive_i(rdrv), .reset_pin_o(rpin), .irq_a_o(irqa),
    .irq_c_o(irqc));
  gafm_pins i_pins (.pad_i(pad), .board_i(board), .lvl_o(pad_in));

  initial forever #2.5 clk_i = ~clk_i;
  // a hang counts as a mismatch and ends the run
  always @(posedge clk_i) begin
    cycles++;
    if (cycles == 20000) begin
      errors++;
      results();
    end
  end

  task automatic results();
    $display("compared %0d mismatches %0d", n_compared, errors);
    if (errors == 0 && n_compared > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask : results

  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    n_compared++;
    if (g !== e) begin
      errors++;
      $display("[FAIL] %s expected %h seen %h", nm, e, g);
    end
  endtask : chk

  // request held until ack is sampled high, then released
  task automatic wb(input logic w, input logic [11:0] i, input logic [15:0] d, output logic [31:0] q);
    @(posedge clk_i);
    cyc <= 1'h1;
    stb <= 1'h1;
    we <= w;
    adr <= {i, 2'h0};
    wdat <= {16'h0000, d};
    do @(posedge clk_i); while (ack !== 1'h1);
    q = rdat;
    cyc <= 1'h0;
    stb <= 1'h0;
    we <= 1'h0;
  endtask : wb

  function automatic logic [11:0] pa(input int p, input logic [1:0] r);
    return IDX_PORT_BASE + 12'(4 * p) + {10'h000, r};
  endfunction : pa

  task automatic wr(input logic [11:0] i, input logic [15:0] d);
    logic [31:0] q;
    wb(1'h1, i, d, q);
  endtask : wr

  task automatic sw(input int p, input logic [7:0] sub, input logic [7:0] d);
    wr(pa(p, REG_SEL), {8'h00, sub});
    wr(pa(p, REG_WIN), {8'h00, d});
  endtask : sw

  task automatic sr(input int p, input logic [7:0] sub, input logic [7:0] e);
    logic [31:0] q;
    wr(pa(p, REG_SEL), {8'h00, sub});
    wb(1'h0, pa(p, REG_WIN), 16'h0000, q);
    chk("window", {24'h0, e}, q);
  endtask : sr

  task automatic settle();
    repeat (2) @(posedge clk_i);
    #1;
  endtask : settle

  task automatic edge_watch(input int p, input int b, input logic v, output logic [15:0] o);
    board[p][b] <= v;
    o = 16'h0000;
    repeat (3) begin
      @(posedge clk_i);
      #1 o = o | {irqc, irqa};
    end
  endtask : edge_watch

  initial begin
    repeat (20) @(posedge clk_i);
    rst_i <= 1'h0;
    @(posedge clk_i);
    #1 chk("irq_idle", 16'h0000, {irqc, irqa});
    settle();
    // ----------------------------------------
    // reset values and selector map
    // ----------------------------------------
    // pd0 starts as reset pin
    chk("pd0_od", 1, pad[PORT_D].od[0]);
    for (int p = 0; p < 4; p++) begin
      for (int k = 0; k <= 9; k++) begin
        ex = (k == 1) ? RST_DIR : (k == 7 && p == PORT_D) ? RST_FS1_D : RST_ZERO;
        sr(p, 8'(k), ex);
      end
    end
    for (int k = 1; k <= 8; k++) sw(PORT_B, 8'(k), 8'(8'h10 + k));
    sw(PORT_B, 8'h00, 8'hAA);
    sw(PORT_B, 8'h09, 8'hAA);
    sw(PORT_A, SUB_FS1, 8'hFF);
    sw(PORT_A, SUB_FS2, 8'hFF);
    for (int k = 1; k <= 8; k++) sr(PORT_B, 8'(k), 8'(8'h10 + k));
    sr(PORT_A, SUB_FS1, 8'h00);
    sr(PORT_A, SUB_FS2, 8'h00);
    $display("test map done");
    // bit 3 left at zero keeps the clock input
    sw(PORT_B, SUB_AF, 8'h3F);
    sw(PORT_B, SUB_FS1, 8'h37);
    board[PORT_B][PB_EXT_CLOCK_INPUT] <= 1'h0;
    settle();
    chk("pb_an", 6'h37, pban);
    chk("ck_sel", 1, ecs);
    chk("ck_in", 0, eci);
    board[PORT_B][PB_EXT_CLOCK_INPUT] <= 1'h1;
    settle();
    chk("ck_in", 1, eci);
    sw(PORT_B, SUB_FS1, 8'h3F);
    settle();
    chk("pb_an", 6'h3F, pban);
    chk("ck_sel", 0, ecs);
    $display("test port b done");
    // pins 0 to 3 get the four sink codes, pins 4 to 7 repeat them
    wr(IDX_LED, 16'hE4E4);
    sw(PORT_C, SUB_AF, 8'hFF);
    sw(PORT_C, SUB_FS1, 8'hF7);
    wr(pa(PORT_C, REG_OUT), 16'h0010);
    cmp <= 1'h1;
    settle();
    chk("led_lvl", {2{LED_20MA, LED_13MA, LED_7MA, LED_3MA}}, ledl);
    chk("led_act", 8'hF7, leda);
    chk("pc_an", 3'h7, pcan);
    chk("pc_oe", 8'h18, pad[PORT_C].oe);
    chk("pc_do", 8'h08, pad[PORT_C].dout & 8'h18);
    sw(PORT_C, SUB_FS1, 8'h00);
    settle();
    chk("led_act", 8'h00, leda);
    $display("test port c done");
    // reset mode then output only gpio
    rdrv <= 1'h1;
    settle();
    chk("pd_oe", 8'h01, pad[PORT_D].oe);
    chk("rst_pin", 0, rpin);
    rdrv <= 1'h0;
    sw(PORT_D, SUB_FS1, 8'h00);
    wr(pa(PORT_D, REG_OUT), 16'h0001);
    settle();
    chk("pd_oe", 8'h01, pad[PORT_D].oe);
    chk("pd_do", 1, pad[PORT_D].dout[0]);
    chk("pd_od", 0, pad[PORT_D].od[0]);
    $display("test port d done");
    // crystal takes the two low port a pins
    sw(PORT_A, SUB_DIR, 8'h00);
    wr(pa(PORT_A, REG_OUT), 16'h00FF);
    wr(IDX_XTAL, 16'h0001);
    settle();
    chk("xtal", 1, xo);
    chk("pa_oe", 8'hFC, pad[PORT_A].oe);
    wr(IDX_XTAL, 16'h0000);
    settle();
    chk("pa_oe", 8'hFF, pad[PORT_A].oe);
    sw(PORT_A, SUB_AF, 8'hC3);
    t0 <= 1'h1;
    board[PORT_A][PA_T1IO] <= 1'h0;
    settle();
    chk("pa_oe", 8'hBE, pad[PORT_A].oe);
    chk("pa_do", 8'h02, pad[PORT_A].dout & 8'h82);
    chk("t0_in", 1, ti0);
    chk("t1_in", 0, ti1);
    {t0d, t1d, t1, t1n} <= 4'hF;
    settle();
    chk("pa_oe", 8'hFF, pad[PORT_A].oe);
    chk("pa_do", 8'hC2, pad[PORT_A].dout & 8'hC3);
    $display("test port a done");
    // chosen edge on port a, any edge on port c
    {t0d, t1d} <= 2'h0;
    sw(PORT_A, SUB_AF, 8'h00);
    sw(PORT_A, SUB_DIR, 8'hFF);
    wr(IDX_EDGE, 16'h0001);
    board[PORT_A] <= 8'h00;
    settle();
    edge_watch(PORT_A, 0, 1'h1, s);
    chk("irq_rise", 16'h0001, s);
    edge_watch(PORT_A, 0, 1'h0, s);
    chk("irq_fall", 16'h0000, s);
    edge_watch(PORT_A, 2, 1'h1, s);
    chk("irq_rise", 16'h0000, s);
    edge_watch(PORT_A, 2, 1'h0, s);
    chk("irq_fall", 16'h0004, s);
    edge_watch(PORT_C, 5, 1'h0, s);
    chk("irq_c", 16'h2000, s);
    $display("test edges done");
    results();
  end
endmodule : tb_gafm_top
